// *** hdl/psu_regs.svh ***
// status longword field positions, reset value and interrupt levels
`ifndef PSU_REGS_SVH
`define PSU_REGS_SVH

`define PSU_BIT_CC_C 0
`define PSU_BIT_CC_V 1
`define PSU_BIT_CC_Z 2
`define PSU_BIT_CC_N 3
`define PSU_BIT_TRACE_EN 4
`define PSU_BIT_INT_OVF_EN 5
`define PSU_BIT_FLT_UNF_EN 6
`define PSU_BIT_DEC_OVF_EN 7
`define PSU_LVL_LSB 16
`define PSU_LVL_MSB 20
`define PSU_PRV_LSB 22
`define PSU_PRV_MSB 23
`define PSU_CUR_LSB 24
`define PSU_CUR_MSB 25
`define PSU_BIT_INT_STACK 26
`define PSU_BIT_FIRST_DONE 27
`define PSU_BIT_TRACE_PEND 30
`define PSU_BIT_COMPAT 31
`define PSU_RESET_VALUE 32'h041f0000
`define PSU_DEFINED_MASK 32'hcfdf00ff
`define PSU_LVL_MAX 5'h1f
`define PSU_LVL_HW_BASE 5'h10
`define PSU_LVL_CONSOLE 5'h14
`define PSU_LVL_TIMER 5'h18
`define PSU_LVL_ERR_LOW 5'h18
`define PSU_LVL_ERR_HIGH 5'h1d
`define PSU_LVL_POWER_FAIL 5'h1e
`define PSU_HW_LEVELS 16

`endif

// *** hdl/psu_pkg.sv ***
// types shared by the status and interrupt unit
package psu_pkg;
  typedef enum logic [1:0] {
    psu_kernel,
    psu_executive,
    psu_supervisor,
    psu_user
  } psu_mode_type;
endpackage

// *** hdl/psu_prio_enc.sv ***
// highest-index request finder
`timescale 1ns/100ps
module psu_prio_enc #(
  parameter int N = 16,
  parameter int W = 4
) (
  input wire logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule

// *** hdl/psu_status_unit.sv ***
// processor status longword and interrupt entry logic
`timescale 1ns/100ps
`include "psu_regs.svh"
module psu_status_unit
  import psu_pkg::*;
#(
  parameter logic [4:0] RECOV_ERR_LEVEL = `PSU_LVL_ERR_LOW,
  parameter logic [4:0] UNREC_ERR_LEVEL = `PSU_LVL_ERR_HIGH
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] program_counter,
  input wire logic instr_begin,
  input wire logic instr_end,
  input wire logic irq_point,
  input wire logic cc_wr,
  input wire logic [3:0] cc_in,
  input wire logic int_ovf_evt,
  input wire logic flt_unf_evt,
  input wire logic dec_ovf_evt,
  input wire logic psw_wr,
  input wire logic [7:0] psw_wdata,
  input wire logic lvl_wr,
  input wire logic [4:0] lvl_wdata,
  input wire logic first_done_set,
  input wire logic first_done_clr,
  input wire logic rsvd_instr_decoded,
  input wire logic exc_req,
  input wire logic [1:0] exc_mode,
  input wire logic exc_on_int_stack,
  input wire logic rei_req,
  input wire logic [31:0] rei_psl,
  input wire logic [31:0] rei_pc,
  input wire logic [7:0] device_irq,
  input wire logic console_irq,
  input wire logic timer_irq,
  input wire logic recov_err_irq,
  input wire logic unrec_err_irq,
  input wire logic power_fail_irq,
  output logic [31:0] status_longword,
  output logic frame_push,
  output logic [31:0] saved_pc,
  output logic [31:0] saved_psl,
  output logic restore_done,
  output logic [31:0] restored_pc,
  output logic irq_ack,
  output logic [4:0] irq_ack_level,
  output logic trace_fault,
  output logic int_ovf_trap,
  output logic flt_unf_exc,
  output logic dec_ovf_trap,
  output logic rsvd_operand_fault,
  output logic priv_fault,
  output logic rsvd_instr_fault,
  output logic resume_midpoint,
  output logic compat_mode
);

  // ****************************************
  // request vector over the hardware levels
  // ****************************************
  logic [`PSU_HW_LEVELS-1:0] lvl_req;
  logic [`PSU_HW_LEVELS-1:0] lvl_above;
  logic best_any;
  logic [3:0] best_idx;
  logic [4:0] best_level;
  logic [4:0] cur_level;
  logic [31:0] psl_ff, nxt_psl;

  always_comb begin
    lvl_req = '0;
    lvl_req[7:0] = device_irq;
    lvl_req[4'(`PSU_LVL_CONSOLE - `PSU_LVL_HW_BASE)] = device_irq[4] | console_irq;
    lvl_req[4'(`PSU_LVL_TIMER - `PSU_LVL_HW_BASE)] = timer_irq | lvl_req[8];
    lvl_req[4'(RECOV_ERR_LEVEL - `PSU_LVL_HW_BASE)] = recov_err_irq
      | lvl_req[4'(RECOV_ERR_LEVEL - `PSU_LVL_HW_BASE)];
    lvl_req[4'(UNREC_ERR_LEVEL - `PSU_LVL_HW_BASE)] = unrec_err_irq
      | lvl_req[4'(UNREC_ERR_LEVEL - `PSU_LVL_HW_BASE)];
    lvl_req[4'(`PSU_LVL_POWER_FAIL - `PSU_LVL_HW_BASE)] = power_fail_irq;
  end

  assign cur_level = psl_ff[`PSU_LVL_MSB:`PSU_LVL_LSB];

  // requests at or below the current level stay masked but are not dropped
  always_comb begin
    for (int i = 0; i < `PSU_HW_LEVELS; i++) begin
      lvl_above[i] = lvl_req[i] && (5'(i + `PSU_LVL_HW_BASE) > cur_level);
    end
  end

  psu_prio_enc #(
    .N(`PSU_HW_LEVELS),
    .W(4)
  ) u_prio (
    .req(lvl_above),
    .any(best_any),
    .idx(best_idx)
  );

  assign best_level = {1'b1, best_idx};

  // ****************************************
  // status longword and event state
  // ****************************************
  logic frame_push_ff, nxt_frame_push;
  logic [31:0] saved_pc_ff, nxt_saved_pc;
  logic [31:0] saved_psl_ff, nxt_saved_psl;
  logic restore_done_ff, nxt_restore_done;
  logic [31:0] restored_pc_ff, nxt_restored_pc;
  logic irq_ack_ff, nxt_irq_ack;
  logic [4:0] irq_ack_level_ff, nxt_irq_ack_level;
  logic trace_fault_ff, nxt_trace_fault;
  logic int_ovf_trap_ff, nxt_int_ovf_trap;
  logic flt_unf_exc_ff, nxt_flt_unf_exc;
  logic dec_ovf_trap_ff, nxt_dec_ovf_trap;
  logic rsvd_operand_fault_ff, nxt_rsvd_operand_fault;
  logic priv_fault_ff, nxt_priv_fault;
  logic rsvd_instr_fault_ff, nxt_rsvd_instr_fault;

  psu_mode_type cur_mode, new_cur_mode, new_prv_mode;
  logic [4:0] new_level;
  logic new_on_stack;
  logic rei_undefined, rei_raises, rei_stack_bad;

  assign cur_mode = psu_mode_type'(psl_ff[`PSU_CUR_MSB:`PSU_CUR_LSB]);
  assign new_cur_mode = psu_mode_type'(rei_psl[`PSU_CUR_MSB:`PSU_CUR_LSB]);
  assign new_prv_mode = psu_mode_type'(rei_psl[`PSU_PRV_MSB:`PSU_PRV_LSB]);
  assign new_level = rei_psl[`PSU_LVL_MSB:`PSU_LVL_LSB];
  assign new_on_stack = rei_psl[`PSU_BIT_INT_STACK];

  // checks on the status that a return wants to restore
  always_comb begin
    rei_undefined = |(rei_psl & ~`PSU_DEFINED_MASK);
    rei_raises = (new_cur_mode < cur_mode) || (new_prv_mode < new_cur_mode)
      || (new_level > cur_level)
      || (new_on_stack && !psl_ff[`PSU_BIT_INT_STACK]);
    rei_stack_bad = new_on_stack && ((new_cur_mode != psu_kernel) || (new_level == 5'h00));
  end

  always_comb begin
    nxt_psl = psl_ff;
    nxt_frame_push = 1'b0;
    nxt_saved_pc = saved_pc_ff;
    nxt_saved_psl = saved_psl_ff;
    nxt_restore_done = 1'b0;
    nxt_restored_pc = restored_pc_ff;
    nxt_irq_ack = 1'b0;
    nxt_irq_ack_level = irq_ack_level_ff;
    nxt_trace_fault = 1'b0;
    nxt_int_ovf_trap = 1'b0;
    nxt_flt_unf_exc = 1'b0;
    nxt_dec_ovf_trap = 1'b0;
    nxt_rsvd_operand_fault = 1'b0;
    nxt_priv_fault = 1'b0;
    nxt_rsvd_instr_fault = 1'b0;

    // ordinary writes reach the low byte, and the level in kernel mode only
    if (psw_wr) begin
      nxt_psl[7:0] = psw_wdata;
    end
    if (lvl_wr && cur_mode == psu_kernel) begin
      nxt_psl[`PSU_LVL_MSB:`PSU_LVL_LSB] = lvl_wdata;
    end
    if (cc_wr) begin
      nxt_psl[`PSU_BIT_CC_N:`PSU_BIT_CC_C] = cc_in;
    end
    if (first_done_set) begin
      nxt_psl[`PSU_BIT_FIRST_DONE] = 1'b1;
    end else if (first_done_clr) begin
      nxt_psl[`PSU_BIT_FIRST_DONE] = 1'b0;
    end

    if (instr_begin && psl_ff[`PSU_BIT_TRACE_EN]) begin
      nxt_psl[`PSU_BIT_TRACE_PEND] = 1'b1;
    end
    if (instr_end) begin
      nxt_trace_fault = psl_ff[`PSU_BIT_TRACE_PEND];
      if (int_ovf_evt || dec_ovf_evt) begin
        nxt_psl[`PSU_BIT_CC_V] = 1'b1;
      end
      nxt_int_ovf_trap = int_ovf_evt && psl_ff[`PSU_BIT_INT_OVF_EN];
      nxt_flt_unf_exc = flt_unf_evt && psl_ff[`PSU_BIT_FLT_UNF_EN];
      nxt_dec_ovf_trap = dec_ovf_evt && psl_ff[`PSU_BIT_DEC_OVF_EN];
    end
    if (rsvd_instr_decoded) begin
      // first part done stays in the status that the entry will push
      nxt_rsvd_instr_fault = psl_ff[`PSU_BIT_FIRST_DONE];
    end

    if (rei_req) begin
      if (rei_undefined || rei_stack_bad) begin
        nxt_rsvd_operand_fault = 1'b1;
        nxt_psl = psl_ff;
      end else if (rei_raises) begin
        nxt_priv_fault = 1'b1;
        nxt_psl = psl_ff;
      end else begin
        nxt_psl = rei_psl & `PSU_DEFINED_MASK;
        nxt_restored_pc = rei_pc;
        nxt_restore_done = 1'b1;
      end
    end else if (exc_req) begin
      nxt_frame_push = 1'b1;
      nxt_saved_pc = program_counter;
      nxt_saved_psl = psl_ff;
      nxt_psl[`PSU_PRV_MSB:`PSU_PRV_LSB] = psl_ff[`PSU_CUR_MSB:`PSU_CUR_LSB];
      nxt_psl[`PSU_CUR_MSB:`PSU_CUR_LSB] = exc_mode;
      nxt_psl[`PSU_BIT_TRACE_PEND] = 1'b0;
      nxt_psl[`PSU_BIT_FIRST_DONE] = 1'b0;
      nxt_psl[`PSU_BIT_COMPAT] = 1'b0;
      nxt_psl[`PSU_BIT_TRACE_EN] = 1'b0;
      if (exc_on_int_stack || psl_ff[`PSU_BIT_INT_STACK]) begin
        nxt_psl[`PSU_BIT_INT_STACK] = 1'b1;
        nxt_psl[`PSU_CUR_MSB:`PSU_CUR_LSB] = 2'(psu_kernel);
        if (cur_level == 5'h00) begin
          nxt_psl[`PSU_LVL_MSB:`PSU_LVL_LSB] = 5'h01;
        end
      end
    end else if (irq_point && best_any) begin
      // taken only at an instruction boundary or a safe midpoint
      nxt_frame_push = 1'b1;
      nxt_saved_pc = program_counter;
      nxt_saved_psl = psl_ff;
      nxt_irq_ack = 1'b1;
      nxt_irq_ack_level = best_level;
      nxt_psl[`PSU_LVL_MSB:`PSU_LVL_LSB] = best_level;
      nxt_psl[`PSU_PRV_MSB:`PSU_PRV_LSB] = 2'(psu_kernel);
      nxt_psl[`PSU_CUR_MSB:`PSU_CUR_LSB] = 2'(psu_kernel);
      nxt_psl[`PSU_BIT_INT_STACK] = 1'b1;
      nxt_psl[`PSU_BIT_TRACE_PEND] = 1'b0;
      nxt_psl[`PSU_BIT_FIRST_DONE] = 1'b0;
      nxt_psl[`PSU_BIT_COMPAT] = 1'b0;
      nxt_psl[`PSU_BIT_TRACE_EN] = 1'b0;
    end

    // no mapping context is held here: entry and return never touch it
    nxt_psl = nxt_psl & `PSU_DEFINED_MASK;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      psl_ff <= `PSU_RESET_VALUE;
      frame_push_ff <= 1'b0;
      saved_pc_ff <= 32'h00000000;
      saved_psl_ff <= 32'h00000000;
      restore_done_ff <= 1'b0;
      restored_pc_ff <= 32'h00000000;
      irq_ack_ff <= 1'b0;
      irq_ack_level_ff <= 5'h00;
      trace_fault_ff <= 1'b0;
      int_ovf_trap_ff <= 1'b0;
      flt_unf_exc_ff <= 1'b0;
      dec_ovf_trap_ff <= 1'b0;
      rsvd_operand_fault_ff <= 1'b0;
      priv_fault_ff <= 1'b0;
      rsvd_instr_fault_ff <= 1'b0;
    end else begin
      psl_ff <= nxt_psl;
      frame_push_ff <= nxt_frame_push;
      saved_pc_ff <= nxt_saved_pc;
      saved_psl_ff <= nxt_saved_psl;
      restore_done_ff <= nxt_restore_done;
      restored_pc_ff <= nxt_restored_pc;
      irq_ack_ff <= nxt_irq_ack;
      irq_ack_level_ff <= nxt_irq_ack_level;
      trace_fault_ff <= nxt_trace_fault;
      int_ovf_trap_ff <= nxt_int_ovf_trap;
      flt_unf_exc_ff <= nxt_flt_unf_exc;
      dec_ovf_trap_ff <= nxt_dec_ovf_trap;
      rsvd_operand_fault_ff <= nxt_rsvd_operand_fault;
      priv_fault_ff <= nxt_priv_fault;
      rsvd_instr_fault_ff <= nxt_rsvd_instr_fault;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign status_longword = psl_ff;
  assign frame_push = frame_push_ff;
  assign saved_pc = saved_pc_ff;
  assign saved_psl = saved_psl_ff;
  assign restore_done = restore_done_ff;
  assign restored_pc = restored_pc_ff;
  assign irq_ack = irq_ack_ff;
  assign irq_ack_level = irq_ack_level_ff;
  assign trace_fault = trace_fault_ff;
  assign int_ovf_trap = int_ovf_trap_ff;
  assign flt_unf_exc = flt_unf_exc_ff;
  assign dec_ovf_trap = dec_ovf_trap_ff;
  assign rsvd_operand_fault = rsvd_operand_fault_ff;
  assign priv_fault = priv_fault_ff;
  assign rsvd_instr_fault = rsvd_instr_fault_ff;
  assign resume_midpoint = psl_ff[`PSU_BIT_FIRST_DONE];
  assign compat_mode = psl_ff[`PSU_BIT_COMPAT];

endmodule

// *** verification/psu_status_monitor.sv ***
// port-level assertions for the status and interrupt unit
`timescale 1ns/100ps
module psu_status_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [31:0] program_counter,
  input wire logic instr_end,
  input wire logic irq_point,
  input wire logic int_ovf_evt,
  input wire logic [31:0] status_longword,
  input wire logic frame_push,
  input wire logic [31:0] saved_pc,
  input wire logic [31:0] saved_psl,
  input wire logic irq_ack,
  input wire logic [4:0] irq_ack_level,
  input wire logic trace_fault,
  input wire logic int_ovf_trap
);
  // ************************************************************
  // status and entry properties
  // ************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_value: assert property ($fell(sys_rst) |-> status_longword == 32'h041f0000)
    else $error("status not at bootstrap value after reset");
  a_reserved_zero: assert property ((status_longword & 32'h3020ff00) == 32'h0)
    else $error("reserved status bit set");
  a_ack_above_level: assert property (irq_ack |-> irq_ack_level > $past(status_longword[20:16]))
    else $error("interrupt taken at or below current level");
  a_ack_sets_level: assert property (irq_ack |-> status_longword[20:16] == irq_ack_level &&
    status_longword[26] && status_longword[25:22] == 4'h0) else $error("interrupt entry status wrong");
  a_stack_kernel: assert property (status_longword[26] |->
    status_longword[25:24] == 2'h0 && status_longword[20:16] != 5'h0) else $error("stack flag without kernel");
  a_push_frame: assert property (frame_push |-> saved_psl == $past(status_longword) &&
    saved_pc == $past(program_counter)) else $error("pushed frame differs from live state");
  a_ack_at_point: assert property (irq_ack |-> $past(irq_point))
    else $error("interrupt taken away from a safe point");
  a_trace_cause: assert property (trace_fault |-> $past(instr_end) && $past(status_longword[30]))
    else $error("trace fault without pending trace");
  a_ovf_trap_cause: assert property (int_ovf_trap |-> $past(instr_end && int_ovf_evt && status_longword[5]))
    else $error("overflow trap without enabled overflow");
endmodule
bind psu_status_unit psu_status_monitor u_mon (.clock, .sys_rst, .program_counter, .instr_end, .irq_point,
  .int_ovf_evt, .status_longword, .frame_push, .saved_pc, .saved_psl, .irq_ack, .irq_ack_level,
  .trace_fault, .int_ovf_trap);

// *** verification/psu_irq_model.sv ***
// interrupt requesters: each line holds until its level is acknowledged
`timescale 1ns/100ps
module psu_irq_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [12:0] req_set,
  input wire logic irq_ack,
  input wire logic [4:0] irq_ack_level,
  output logic [7:0] device_irq,
  output logic console_irq,
  output logic timer_irq,
  output logic recov_err_irq,
  output logic unrec_err_irq,
  output logic power_fail_irq
);
  logic [12:0] pend_ff;
  logic [4:0] lvl [13];
  assign lvl = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h14, 5'h18, 5'h18, 5'h1d, 5'h1e};
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pend_ff <= 13'h0;
    end else begin
      for (int i = 0; i < 13; i++) begin
        if (req_set[i])
          pend_ff[i] <= 1'b1;
        else if (irq_ack && irq_ack_level == lvl[i])
          pend_ff[i] <= 1'b0;
      end
    end
  end
  assign {power_fail_irq, unrec_err_irq, recov_err_irq, timer_irq, console_irq, device_irq} = pend_ff;
endmodule

// *** verification/tb.sv ***
// self-checking bench for the status and interrupt unit
`timescale 1ns/100ps
module tb;
  localparam logic [12:0] BEG = 13'h1, FIN = 13'h2, CCW = 13'h4, IOV = 13'h8, STATUS_WORD_LOW = 13'h40, LVW = 13'h80;
  localparam logic [12:0] FDS = 13'h100, RSV = 13'h400, EXC = 13'h800, RET = 13'h1000;
  logic clock, sys_rst, irq_point, irq_ack, frame_push, restore_done, trace_fault, int_ovf_trap;
  logic flt_unf_exc, dec_ovf_trap, rsvd_operand_fault, priv_fault, rsvd_instr_fault, resume_midpoint, compat_mode;
  logic console_irq, timer_irq, recov_err_irq, unrec_err_irq, power_fail_irq;
  logic [4:0] irq_ack_level;
  logic [7:0] device_irq;
  logic [12:0] stb, req;
  logic [31:0] wd, status_longword, saved_pc, saved_psl, restored_pc;
  logic [31:0] pc_ff = 32'h100;
  logic [4:0] lv [13];
  int n_errors, comparisons;
  assign lv = '{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h14, 5'h18, 5'h18, 5'h1d, 5'h1e};
  psu_status_unit DUT (.clock, .sys_rst, .program_counter(pc_ff), .instr_begin(stb[0]), .instr_end(stb[1]),
    .irq_point, .cc_wr(stb[2]), .cc_in(wd[3:0]), .int_ovf_evt(stb[3]), .flt_unf_evt(stb[4]),
    .dec_ovf_evt(stb[5]), .psw_wr(stb[6]), .psw_wdata(wd[7:0]), .lvl_wr(stb[7]), .lvl_wdata(wd[4:0]),
    .first_done_set(stb[8]), .first_done_clr(stb[9]), .rsvd_instr_decoded(stb[10]), .exc_req(stb[11]),
    .exc_mode(wd[1:0]), .exc_on_int_stack(1'b0), .rei_req(stb[12]), .rei_psl(wd), .rei_pc(~wd), .device_irq,
    .console_irq, .timer_irq, .recov_err_irq, .unrec_err_irq, .power_fail_irq, .status_longword, .frame_push,
    .saved_pc, .saved_psl, .restore_done, .restored_pc, .irq_ack, .irq_ack_level, .trace_fault, .int_ovf_trap,
    .flt_unf_exc, .dec_ovf_trap, .rsvd_operand_fault, .priv_fault, .rsvd_instr_fault, .resume_midpoint,
    .compat_mode);
  psu_irq_model u_req (.clock, .sys_rst, .req_set(req), .irq_ack, .irq_ack_level, .device_irq, .console_irq,
    .timer_irq, .recov_err_irq, .unrec_err_irq, .power_fail_irq);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) pc_ff <= pc_ff + 32'h4;
  // ************************************************************
  // access tasks
  // ************************************************************
  function automatic logic [31:0] f(input logic b); return {31'h0, b}; endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input logic [12:0] m, input logic [31:0] w, input logic [12:0] r = 13'h0);
    @(posedge clock);
    stb <= m;
    wd <= w;
    req <= r;
    @(posedge clock);
    stb <= 13'h0;
    req <= 13'h0;
    #1;
  endtask
  task automatic irqw(input logic [4:0] l, input logic want);
    logic got;
    got = 1'b0;
    @(posedge clock);
    irq_point <= 1'b1;
    for (int k = 0; k < 8 && got !== 1'b1; k++) begin
      @(posedge clock);
      #1 got = irq_ack;
    end
    @(posedge clock);
    irq_point <= 1'b0;
    chk("irq_ack", f(want), f(got));
    if (want && got !== 1'b1) summarize();
    if (got === 1'b1) chk("irq_ack_level", {27'h0, l}, {27'h0, irq_ack_level});
  endtask
  task automatic summarize();
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    stb = 13'h0;
    req = 13'h0;
    wd = 32'h0;
    irq_point = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1 chk("status", 32'h041f0000, status_longword);
    go(RET, 32'h0);
    chk("restored_pc", 32'hffffffff, restored_pc);
    chk("restore_done", 32'h1, f(restore_done));
    go(STATUS_WORD_LOW, 32'hffffffff);
    chk("status", 32'h000000ff, status_longword);
    go(CCW, 32'h5);
    chk("status", 32'h000000f5, status_longword);
    for (int b = 0; b < 3; b++) begin
      for (int en = 0; en < 2; en++) begin
        go(STATUS_WORD_LOW, 32'(en) << (b + 5));
        go(FIN | (IOV << b), 32'h0);
        chk("trap", 32'(en), f(b == 0 ? int_ovf_trap : b == 1 ? flt_unf_exc : dec_ovf_trap));
        if (b != 1) chk("v_flag", 32'h1, f(status_longword[1]));
      end
    end
    go(STATUS_WORD_LOW, 32'h10);
    go(BEG, 32'h0);
    chk("status", 32'h40000010, status_longword);
    go(FIN, 32'h0);
    chk("trace_fault", 32'h1, f(trace_fault));
    go(EXC, 32'h0);
    chk("saved_psl", 32'h40000010, saved_psl);
    chk("frame_push", 32'h1, f(frame_push));
    go(RET, 32'h03c00000);
    chk("status", 32'h03c00000, status_longword);
    go(RET, 32'h0);
    chk("priv_fault", 32'h1, f(priv_fault));
    chk("status", 32'h03c00000, status_longword);
    go(EXC, 32'h0);
    chk("status", 32'h00c00000, status_longword);
    go(RET, 32'h04000000);
    chk("rsvd_operand_fault", 32'h1, f(rsvd_operand_fault));
    go(RET, 32'h00000100);
    chk("rsvd_operand_fault", 32'h1, f(rsvd_operand_fault));
    go(RET, 32'h80000000);
    chk("compat_mode", 32'h1, f(compat_mode));
    go(FDS, 32'h0);
    chk("resume_midpoint", 32'h1, f(resume_midpoint));
    go(RSV, 32'h0);
    chk("rsvd_instr_fault", 32'h1, f(rsvd_instr_fault));
    go(RET, 32'h0);
    chk("compat_mode", 32'h0, f(compat_mode));
    go(LVW, 32'h12, 13'h002);
    irqw(5'h11, 1'b0);
    go(13'h0, 32'h0, 13'h008);
    irqw(5'h13, 1'b1);
    chk("status", 32'h04130000, status_longword);
    go(RET, 32'h0);
    irqw(5'h11, 1'b1);
    go(RET, 32'h0, 13'h1001);
    irqw(5'h1e, 1'b1);
    go(RET, 32'h0);
    irqw(5'h10, 1'b1);
    for (int i = 0; i < 13; i++) begin
      go(RET, 32'h0, 13'(1) << i);
      irqw(lv[i], 1'b1);
      chk("status", {11'h020, lv[i], 16'h0}, status_longword);
    end
    summarize();
  end
endmodule
